// file: design/iive_top.sv
// Internal interrupt vector encoder with its AHB-Lite register slave.
// Assumes one-cycle source event pulses and a single-slave AHB-Lite bus.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
module iive_top (
   // Clock, reset and clock enable.
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // Peripheral event pulses, bit = group * 8 + index.
   input wire iive_pkg::iive_src_type src_event,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Combined request to the core, active low level.
   output logic combined_internal_request_b,
   // Presented vector for observation.
   output logic [7:0] interrupt_source_vector
);
   import iive_pkg::*;

   iive_enc_if enc_bus ();

   iive_encoder u_encoder (
      .enc(enc_bus.enc)
   );

   // Source bookkeeping state.
   iive_src_type pending;
   iive_src_type next_pending;
   iive_age_type blocked [SOURCES];
   iive_age_type next_blocked [SOURCES];
   iive_src_type retire;
   iive_src_type kept;
   iive_src_type arrive;

   // Vector register state.
   logic [7:0] next_vector;
   logic next_request_b;
   logic retire_now;

   // Bus data-phase state.
   logic dp_valid;
   logic next_dp_valid;
   logic dp_write;
   logic next_dp_write;
   logic [31:0] dp_addr;
   logic [31:0] next_dp_addr;
   logic [31:0] next_hrdata;
   logic addr_taken;

   function automatic logic [31:0] read_mux(
      input logic [31:0] addr,
      input logic [7:0] vec,
      input iive_src_type pend);
      logic [31:0] data;
      data = RDATA_ZERO;
      if (addr == VEC_REG_ADDR) begin
         data[VEC_W-1:0] = vec;
      end else if (addr == PEND_LO_ADDR) begin
         data = pend[31:0];
      end else if (addr == PEND_MID_ADDR) begin
         data = pend[63:32];
      end else if (addr == PEND_HI_ADDR) begin
         data[SLOTS-1:0] = pend[SOURCES-1:64];
      end
      read_mux = data;
   endfunction

   // The write data is ignored: any write to the vector acknowledges it.
   assign retire_now = dp_valid && dp_write && hready &&
                       (dp_addr == VEC_REG_ADDR);
   assign addr_taken = hsel && hready && (htrans == HTRANS_NONSEQ ||
                       htrans[1]);

   assign enc_bus.pending = kept;
   assign enc_bus.blocked = blocked;

   // Pending set and arrival order.
   always_comb begin
      retire = '0;
      if (retire_now && interrupt_source_vector != NO_VECTOR) begin
         retire[interrupt_source_vector[7:1]] = 1'b1;
      end
      kept = pending & ~retire;
      // A new event wins over a retire in the same cycle.
      arrive = src_event & USED_MASK & ~kept;
      next_pending = kept | arrive;
      for (int s = 0; s < SOURCES; s++) begin
         next_blocked[s] = blocked[s];
         for (int j = 0; j < SLOTS; j++) begin
            if (arrive[s]) begin
               next_blocked[s][j] = kept[(s/SLOTS)*SLOTS+j] |
                  (arrive[(s/SLOTS)*SLOTS+j] && j < (s % SLOTS));
            end else if (arrive[(s/SLOTS)*SLOTS+j]) begin
               // A newcomer never blocks a source that is already waiting.
               next_blocked[s][j] = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pending <= '0;
         for (int s = 0; s < SOURCES; s++) begin
            blocked[s] <= '0;
         end
      end else if (ce) begin
         pending <= next_pending;
         blocked <= next_blocked;
      end
   end

   // Vector register and combined request.
   always_comb begin
      next_vector = interrupt_source_vector;
      if (retire_now) begin
         next_vector = enc_bus.head_valid ? enc_bus.head_code
                                          : NO_VECTOR;
      end else if (interrupt_source_vector == NO_VECTOR &&
                   enc_bus.head_valid) begin
         next_vector = enc_bus.head_code;
      end
      next_request_b = ~|next_pending;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         interrupt_source_vector <= VEC_RESET;
         combined_internal_request_b <= 1'b1;
      end else if (ce) begin
         interrupt_source_vector <= next_vector;
         combined_internal_request_b <= next_request_b;
      end
   end

   // AHB-Lite address and data phases; zero wait states, always OKAY.
   always_comb begin
      next_dp_valid = addr_taken;
      next_dp_write = dp_write;
      next_dp_addr = dp_addr;
      next_hrdata = hrdata;
      if (addr_taken) begin
         next_dp_write = hwrite;
         next_dp_addr = haddr;
         if (!hwrite) begin
            // Reads see the vector as it stands after any retire now.
            next_hrdata = read_mux(haddr, next_vector, next_pending);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= RDATA_ZERO;
         hrdata <= RDATA_ZERO;
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end else if (ce) begin
         dp_valid <= next_dp_valid;
         dp_write <= next_dp_write;
         dp_addr <= next_dp_addr;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end
   end
endmodule

// file: design/iive_pkg.sv
// Constants, register map and code layout of the internal vector encoder.
// Assumes one 125 MHz clock and an AHB-Lite register slave.
//
// Overview of operation
// - Vector register names the internal source behind the shared interrupt.
// - Any write to the vector register retires the presented source and loads the next pending one.
// - Bit 0 of every vector code reads as zero.
// - Vector reads zero while nothing is pending.
// - Code is group in bits 7..4, index in bits 3..1, read-only.
// - Within a group, sources are presented earliest-pending first.
// - Higher group number wins; group zero is lowest.
// - Group 1 carries host-to-device endpoints 1..3 at 12, 14, 16 hex.
// - Group 2 carries device-to-host endpoints 1..3 at 22, 24, 26 hex.
// - Group 3: setup overwrite, setup, resume, suspend, reset, wakeup.
// - Group 4: I2C transmit, I2C receive, control in, control out.
// - Group 5: UART line status at 50, modem signals at 52 hex.
// - Group 6: UART receive full at 60, transmit empty at 62 hex.
// - Fixed, non-programmable priority encoder yields an 8-bit code.
// - Group 8 (80, 84 hex) ranks highest, group 1 (12..16 hex) lowest among used.
// - All sources OR into one active-low level request.
package iive_pkg;
   localparam int GROUPS = 9;
   localparam int SLOTS = 8;
   localparam int SOURCES = 72;
   localparam int SRC_W = 7;
   localparam int DATA_W = 32;
   localparam int VEC_W = 8;
   // Only wired sources can ever become pending.
   localparam logic [71:0] USED_MASK = 72'h05_00_03_03_0F_F3_0E_0E_00;
   localparam logic [7:0] NO_VECTOR = 8'h00;
   localparam logic [7:0] VEC_RESET = 8'h00;
   localparam logic CODE_LSB = 1'b0;
   localparam logic [31:0] VEC_REG_INDEX = 32'h0000_FF92;
   localparam logic [31:0] PEND_LO_INDEX = 32'h0000_FFA0;
   localparam logic [31:0] PEND_MID_INDEX = 32'h0000_FFA1;
   localparam logic [31:0] PEND_HI_INDEX = 32'h0000_FFA2;
   localparam logic [31:0] VEC_REG_ADDR = VEC_REG_INDEX << 2;
   localparam logic [31:0] PEND_LO_ADDR = PEND_LO_INDEX << 2;
   localparam logic [31:0] PEND_MID_ADDR = PEND_MID_INDEX << 2;
   localparam logic [31:0] PEND_HI_ADDR = PEND_HI_INDEX << 2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
   typedef logic [SLOTS-1:0] iive_age_type;
   typedef logic [SOURCES-1:0] iive_src_type;
endpackage

// file: design/iive_enc_if.sv
// Carrier between the vector register logic and the priority encoder.
// Assumes both ends run combinationally within one clock domain.
`timescale 1ns/10ps
interface iive_enc_if;
   import iive_pkg::*;
   iive_src_type pending;
   iive_age_type blocked [SOURCES];
   logic head_valid;
   logic [VEC_W-1:0] head_code;
   modport ctrl (output pending, output blocked,
                 input head_valid, input head_code);
   modport enc (input pending, input blocked,
                output head_valid, output head_code);
endinterface

// file: design/iive_encoder.sv
// Fixed priority encoder: picks the oldest pending source of the
// highest pending group. Assumes the age matrix is kept by its user.
`timescale 1ns/10ps
module iive_encoder (
   // Pending set, age matrix and head.
   iive_enc_if.enc enc
);
   import iive_pkg::*;

   function automatic logic [7:0] make_code(input int g, input int i);
      make_code = {g[3:0], i[2:0], CODE_LSB};
   endfunction

   logic [SOURCES-1:0] oldest;

   // A source is oldest when no pending source of its group came first.
   genvar s;
   generate
      for (s = 0; s < SOURCES; s++) begin : g_old
         localparam int BASE = (s / SLOTS) * SLOTS;
         assign oldest[s] = enc.pending[s] &
            ~|(enc.pending[BASE +: SLOTS] & enc.blocked[s]);
      end
   endgenerate

   // Later, higher groups overwrite earlier ones; lower index breaks ties.
   always_comb begin
      enc.head_valid = 1'b0;
      enc.head_code = NO_VECTOR;
      for (int g = 0; g < GROUPS; g++) begin
         for (int i = SLOTS - 1; i >= 0; i--) begin
            if (oldest[g*SLOTS+i]) begin
               enc.head_valid = 1'b1;
               enc.head_code = make_code(g, i);
            end
         end
      end
   end
endmodule

// file: bench/iive_monitor.sv
// Port checker for the vector encoder top.
// Assumes one clock, rst_b active low.
`timescale 1ns/10ps
module iive_monitor (
   // Clock and bus.
   input wire logic clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   // Outputs.
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic combined_internal_request_b,
   input wire logic [7:0] interrupt_source_vector
);
   import iive_pkg::*;
   wire req_b = combined_internal_request_b;
   wire [7:0] vec = interrupt_source_vector;
   wire ack = hsel && htrans[1] && hwrite && haddr == VEC_REG_ADDR;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence new_pend; req_b ##1 !req_b; endsequence
   chk_lsb_zero: assert property (!vec[0]) else $error("odd code");
   chk_idle_zero: assert property (req_b |-> !vec) else $error("idle");
   chk_vec_req: assert property (vec |-> !req_b) else $error("no req");
   chk_used_code: assert property
      (!vec || USED_MASK[vec[7:1]]) else $error("unused code");
   chk_group_range: assert property
      (vec[7:4] <= 4'h8 && vec[7:4] != 4'h7) else $error("bad group");
   chk_hold_vec: assert property
      (vec && !$past(ack) |=> $stable(vec)) else $error("moved");
   chk_retire_only: assert property
      ($rose(req_b) |-> $past(ack, 2)) else $error("dropped");
   chk_bus_okay: assert property
      (hreadyout && hresp == HRESP_OKAY) else $error("bus not okay");
   chk_fill_delay: assert property
      (new_pend |=> vec) else $error("not loaded");
endmodule
bind iive_top iive_monitor iive_monitor_i (.clk, .rst_b, .hsel, .haddr,
   .htrans, .hwrite, .hreadyout, .hresp, .combined_internal_request_b,
   .interrupt_source_vector);

// file: bench/iive_mcu_model.sv
// Bus master side of the microcontroller core.
// Assumes one slave whose hreadyout is hready.
`timescale 1ns/10ps
module iive_mcu_model (
   // Clock and bus return.
   input wire logic clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // Bus request.
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [31:0] hwdata
);
   import iive_pkg::*;
   initial {haddr, htrans, hwrite, hwdata} = '0;
   task automatic xfer(input logic w, input logic [31:0] a, d,
         output logic [31:0] r);
      @(posedge clk);
      {haddr, htrans, hwrite} <= {a, HTRANS_NONSEQ, w};
      do @(posedge clk); while (hready !== 1'b1);
      {htrans, hwdata} <= {2'h0, d};
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
      hwdata <= ~d;
   endtask
endmodule

// file: bench/tb_top.sv
// Bench top: fires source events, checks what the core reads.
// Assumes the checker binds itself to the design top.
`timescale 1ns/10ps
module tb_top;
   import iive_pkg::*;
   localparam iive_src_type ONE = 1;
   logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, hsel = 1'b1;
   logic hwrite, hready, hreadyout, req_b;
   logic [1:0] htrans;
   logic [2:0] hsize = 3'h2;
   logic [7:0] vec;
   logic [31:0] haddr, hwdata, hrdata, rd;
   iive_src_type src_event = '0;
   int err_total = 0, n_checks = 0;
   int bits [22] = '{9, 10, 11, 17, 18, 19, 24, 25, 28, 29, 30, 31, 32,
      33, 34, 35, 40, 41, 48, 49, 64, 66};
   logic [7:0] ord [6] = '{8'h80, 8'h44, 8'h3E, 8'h30, 8'h38, 8'h12};
   always #4 clk = ~clk;
   assign hready = hreadyout;
   iive_top iive_top_i (.clk, .rst_b, .ce, .src_event, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
      .hresp(), .combined_internal_request_b(req_b),
      .interrupt_source_vector(vec));
   iive_mcu_model iive_mcu_model_i (.clk, .hready, .hrdata, .haddr,
      .htrans, .hwrite, .hwdata);
   task automatic check(input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) err_total++;
      if (got !== exp) $display("MISMATCH %0t %h %h", $time, got, exp);
   endtask
   task automatic fire(input iive_src_type m);
      @(posedge clk);
      src_event <= m;
      @(posedge clk);
      src_event <= '0;
   endtask
   // Dispatch on the low level: read the code, then retire it.
   task automatic serve(input logic [7:0] e);
      @(posedge clk);
      wait (req_b === 1'b0);
      iive_mcu_model_i.xfer(1'b0, VEC_REG_ADDR, 32'h0, rd);
      check(rd, {24'h0, e});
      iive_mcu_model_i.xfer(1'b1, VEC_REG_ADDR, ~rd, rd);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      iive_mcu_model_i.xfer(1'b0, VEC_REG_ADDR, 32'h0, rd);
      check(rd, 32'h0);
      iive_mcu_model_i.xfer(1'b0, 32'h100, 32'h0, rd);
      check(rd, 32'h0);
      $display("reset test done");
      foreach (bits[i]) begin
         fire(ONE << bits[i]);
         serve(8'(2 * bits[i]));
      end
      $display("source map test done");
      fire(ONE << 9 | ONE << 34 | ONE << 64);
      fire(ONE << 31);
      fire(ONE << 24);
      fire(ONE << 28);
      iive_mcu_model_i.xfer(1'b0, PEND_LO_ADDR, 32'h0, rd);
      check(rd, 32'h9100_0200);
      iive_mcu_model_i.xfer(1'b0, PEND_MID_ADDR, 32'h0, rd);
      check(rd, 32'h0000_0004);
      iive_mcu_model_i.xfer(1'b0, PEND_HI_ADDR, 32'h0, rd);
      check(rd, 32'h0000_0001);
      foreach (ord[i]) serve(ord[i]);
      $display("priority test done");
      fire(ONE << 25 | ONE << 24);
      serve(8'h30);
      serve(8'h32);
      fire(ONE << 28);
      fire(ONE << 29);
      fire(ONE << 32);
      serve(8'h38);
      fire(ONE << 28);
      serve(8'h40);
      serve(8'h3A);
      serve(8'h38);
      $display("arrival order test done");
      ce <= 1'b0;
      fire(ONE << 9);
      repeat (2) @(posedge clk);
      check({31'h0, req_b}, 32'h1);
      ce <= 1'b1;
      $display("clock enable test done");
      tally_and_finish;
   end
   initial begin
      #50000 err_total++;
      tally_and_finish;
   end
endmodule
